//--- logic/hpif_top.sv
// Overview of operation
// - Mask bits 0-2 enable each input
// - Mask bits 4-6 pick rising or falling
// - Enabled inputs watched every clock continuously
// - Detected edge updates flags next cycle
// - Trigger sets own flag and summary
// - Enable mask alone raises no interrupt
// - Flag selection mask raises program interrupt
// - Enabled trigger wakes from sleep/doze
module hpif_top
   import hpif_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic resetn,
   // Interrupt pins
   input wire logic ext_irq_in_0,
   input wire logic ext_irq_in_1,
   input wire logic ext_irq_in_2,
   // Configuration
   input wire logic [7:0] cfg_mask,
   input wire logic [3:0] flag_sel,
   // Software flag clears, one per flag, bit 3 summary
   input wire logic [3:0] flag_clr,
   // Status
   output logic [2:0] pin_flag,
   output logic summary_flag,
   output logic prog_irq,
   output logic wake_req
);
   import hpif_pkg::*;

   // ==========================================
   // Reset release
   logic [1:0] rst_sync_q;
   logic rst_n;

   // Async assert, sync release
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         rst_sync_q <= 2'h0;
      end
      else
      begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_q[1];

   // ==========================================
   // Pin synchroniser
   hpif_sync_if sync_bus ();

   // Two stages ahead of edge compare
   hpif_sync u_sync (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .pin_raw({ext_irq_in_2, ext_irq_in_1, ext_irq_in_0}),
      .sync(sync_bus)
   );

   // ==========================================
   // State
   typedef struct packed
   {
      logic [2:0] prev;     // Last synchronised level
      logic [2:0] flags;    // Per-pin flags
      logic summary;        // Shared flag
      logic irq;            // Program interrupt
      logic wake;           // Wake pulse
   } hpif_state_t;

   hpif_state_t state_q;
   hpif_state_t state_d;
   logic [2:0] trig;

   // Logic is sized for exactly three pins and two sync stages
   if (HPIF_NUM_PINS != 3 || HPIF_SYNC_STAGES != 2)
   begin : g_size_chk
      $error("unsupported pin count or sync depth");
   end

   // Edge match for one pin
   function automatic logic hpif_edge(input logic cur, input logic old, input logic rise);
      hpif_edge = (rise == HPIF_EDGE_RISE) ? (cur & ~old) : (~cur & old);
   endfunction : hpif_edge

   // Per-pin trigger detection
   generate
      for (genvar i = 0; i < HPIF_NUM_PINS; i++)
      begin : g_trig
         // Watched every clock, gated by enable
         assign trig[i] = cfg_mask[HPIF_EN_LSB + i]
            & hpif_edge(sync_bus.pin_level[i], state_q.prev[i],
                        cfg_mask[HPIF_EDGE_LSB + i]);
      end
   endgenerate

   // Next state
   always_comb
   begin
      state_d = state_q;
      state_d.prev = sync_bus.pin_level;
      // Clear only on software request; set wins
      state_d.flags = (state_q.flags & ~flag_clr[2:0]) | trig;
      state_d.summary = (state_q.summary & ~flag_clr[3]) | (|trig);
      // Interrupt only from selected flags, not the enable
      state_d.irq = |({state_d.summary, state_d.flags} & flag_sel);
      // Any enabled trigger wakes the core
      state_d.wake = |trig;
   end

   // Register the state; no filtering of bounce
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_q <= '0;
         state_q.flags <= HPIF_FLAG_RST;
      end
      else
      begin
         state_q <= state_d;
      end
   end

   assign pin_flag = state_q.flags;
   assign summary_flag = state_q.summary;
   assign prog_irq = state_q.irq;
   assign wake_req = state_q.wake;
endmodule : hpif_top

//--- logic/hpif_pkg.sv
package hpif_pkg;
   // ==========================================
   // Configuration mask layout
   localparam int HPIF_NUM_PINS = 3;        // Interrupt inputs
   localparam int HPIF_EN_LSB = 0;          // Enable bits 0..2
   localparam int HPIF_EDGE_LSB = 4;        // Edge select bits 4..6
   localparam logic [7:0] HPIF_MASK_RST = 8'h00; // All pins off at reset
   localparam logic [2:0] HPIF_FLAG_RST = 3'h0;  // Flags clear at reset
   // Edge polarity encoding
   localparam logic HPIF_EDGE_RISE = 1'b1;  // One selects rising
   localparam logic HPIF_EDGE_FALL = 1'b0;  // Zero selects falling
   // Synchroniser depth
   localparam int HPIF_SYNC_STAGES = 2;
endpackage : hpif_pkg

//--- logic/hpif_sync_if.sv
// Carries synchronised pin levels between the modules
interface hpif_sync_if;
   logic [2:0] pin_level; // Synchronised pin levels
   modport src (output pin_level);
   modport dst (input pin_level);
endinterface : hpif_sync_if

//--- logic/hpif_sync.sv
// ==========================================
// Two-stage pin synchroniser
module hpif_sync
   import hpif_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // Raw pins
   input wire logic [2:0] pin_raw,
   // Synchronised levels
   hpif_sync_if.src sync
);
   // State record: first and second stage
   typedef struct packed
   {
      logic [2:0] meta;
      logic [2:0] stable;
   } hpif_sync_state_t;

   hpif_sync_state_t state_q;
   hpif_sync_state_t state_d;

   // Next state: first stage read only by second
   always_comb
   begin
      state_d = state_q;
      state_d.meta = pin_raw;
      state_d.stable = state_q.meta;
   end

   // Register the state
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_q <= '0;
      end
      else
      begin
         state_q <= state_d;
      end
   end

   assign sync.pin_level = state_q.stable;
endmodule : hpif_sync

//--- dv/hpif_pins.sv
// ==========================================
// Far-side switch model
module hpif_pins (
   // Clock
   input wire logic clk_sys,
   // Wanted levels
   input wire logic [2:0] want,
   // Pin levels
   output logic [2:0] pins
);
   timeunit 1ns;
   timeprecision 1ns;
   // Clean single edges, debounced
   always_ff @(posedge clk_sys) pins <= want;
endmodule : hpif_pins

//--- dv/hpif_sva.sv
// ==========================================
// Port checker
module hpif_sva (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic resetn,
   // Pins and config
   input wire logic ext_irq_in_0,
   input wire logic ext_irq_in_1,
   input wire logic ext_irq_in_2,
   input wire logic [7:0] cfg_mask,
   input wire logic [3:0] flag_sel,
   input wire logic [3:0] flag_clr,
   // Status
   input wire logic [2:0] pin_flag,
   input wire logic summary_flag,
   input wire logic prog_irq,
   input wire logic wake_req
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   chk_en_gate: assert property ($rose(pin_flag[0]) |-> $past(cfg_mask[0]))
      else $error("flag from disabled pin");
   chk_rise_set: assert property ($rose(ext_irq_in_0) && cfg_mask[0] && cfg_mask[4]
      |-> ##[3:4] pin_flag[0]) else $error("rise missed");
   chk_fall_set: assert property ($fell(ext_irq_in_1) && cfg_mask[1] && !cfg_mask[5]
      |-> ##[3:4] pin_flag[1]) else $error("fall missed");
   chk_sum_set: assert property (|(pin_flag & ~$past(pin_flag)) |-> summary_flag)
      else $error("summary missed");
   chk_irq_sel: assert property (prog_irq == |({summary_flag, pin_flag} & $past(flag_sel)))
      else $error("program irq wrong");
   chk_wake_set: assert property ($rose(pin_flag[1]) |-> wake_req)
      else $error("no wake");
   chk_wake_one: assert property (wake_req |=> !wake_req)
      else $error("wake too long");
   chk_flag_hold: assert property (pin_flag[0] && !flag_clr[0] |=> pin_flag[0])
      else $error("flag lost");
   cover property ($rose(prog_irq));
   cover property ($rose(wake_req));
   cover property ($fell(pin_flag[1]));
endmodule : hpif_sva
bind hpif_top hpif_sva u_sva (
   .clk_sys(clk_sys),
   .resetn(resetn),
   .ext_irq_in_0(ext_irq_in_0),
   .ext_irq_in_1(ext_irq_in_1),
   .ext_irq_in_2(ext_irq_in_2),
   .cfg_mask(cfg_mask),
   .flag_sel(flag_sel),
   .flag_clr(flag_clr),
   .pin_flag(pin_flag),
   .summary_flag(summary_flag),
   .prog_irq(prog_irq),
   .wake_req(wake_req)
);

//--- dv/hpif_top_tb.sv
module hpif_top_tb;
   timeunit 1ns;
   timeprecision 1ns;
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_total++; $display("[ERR] %0t bad", $time); end end
   // Stimulus and status
   logic clk_sys = 1'b0;
   logic resetn = 1'b0;
   logic [2:0] lvl = 3'h0;
   logic [7:0] cfg_mask = 8'h00;
   logic [3:0] flag_sel = 4'h0;
   logic [3:0] flag_clr = 4'h0;
   wire logic [2:0] pins;
   logic [2:0] pin_flag;
   logic summary_flag, prog_irq, wake_req;
   int err_total = 0, n_checks = 0, cyc = 0;
   hpif_pins PM (.clk_sys(clk_sys), .want(lvl), .pins(pins));
   hpif_top DUT (.clk_sys(clk_sys), .resetn(resetn), .ext_irq_in_0(pins[0]),
      .ext_irq_in_1(pins[1]), .ext_irq_in_2(pins[2]), .cfg_mask(cfg_mask),
      .flag_sel(flag_sel), .flag_clr(flag_clr), .pin_flag(pin_flag),
      .summary_flag(summary_flag), .prog_irq(prog_irq), .wake_req(wake_req));
   always #20 clk_sys = ~clk_sys;
   task automatic end_sim();
      if (err_total == 0 && n_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : end_sim
   // Hang guard
   always @(posedge clk_sys)
   begin
      cyc++;
      if (cyc > 2000)
      begin
         err_total++;
         end_sim();
      end
   end
   task automatic wt(int n);
      repeat (n) @(posedge clk_sys);
   endtask : wt
   // Clear all flags
   task automatic t_clr();
      flag_clr <= 4'hF;
      wt(1);
      flag_clr <= 4'h0;
      wt(2);
      `CHK({pin_flag, summary_flag, prog_irq}, 5'h00)
   endtask : t_clr
   task automatic t_rise();
      cfg_mask <= 8'h11;
      flag_sel <= 4'h1;
      wt(2);
      lvl <= 3'h1;
      wt(4);
      #1;
      `CHK(wake_req, 1'b1)
      wt(1);
      #1;
      `CHK(wake_req, 1'b0)
      wt(1);
      `CHK({pin_flag, summary_flag, prog_irq}, 5'h07)
      lvl <= 3'h0;
      wt(6);
      `CHK(pin_flag, 3'h1)
      t_clr();
   endtask : t_rise
   task automatic t_fall();
      cfg_mask <= 8'h02;
      lvl <= 3'h2;
      wt(6);
      `CHK(pin_flag, 3'h0)
      lvl <= 3'h0;
      wt(6);
      `CHK({pin_flag, summary_flag, prog_irq}, 5'h0A)
      flag_sel <= 4'h8;
      wt(2);
      `CHK(prog_irq, 1'b1)
      t_clr();
   endtask : t_fall
   task automatic t_dis();
      cfg_mask <= 8'h40;
      flag_sel <= 4'hF;
      lvl <= 3'h4;
      wt(6);
      `CHK({pin_flag, summary_flag, prog_irq}, 5'h00)
      lvl <= 3'h0;
   endtask : t_dis
   initial
   begin
      wt(3);
      resetn <= 1'b1;
      wt(4);
      t_rise();
      t_fall();
      t_dis();
      end_sim();
   end
endmodule : hpif_top_tb
